// ==== verilog/urx_regs.vh ====
`ifndef URX_REGS_VH
`define URX_REGS_VH
// ****************************************
// register offsets (byte addresses, 12-bit)
// ****************************************
`define URX_ADDR_W          12
`define URX_OFF_EP0_CSRH    12'h102
`define URX_OFF_EP1_CSRH    12'h117
`define URX_OFF_EP1_CSRL    12'h116
`define URX_OFF_MAXP        12'h114
`define URX_OFF_MODE        12'h118
`define URX_OFF_IRQ_STAT    12'h11C
`define URX_OFF_IRQ_MASK    12'h11D
// ****************************************
// field positions
// ****************************************
`define URX_EP0_TOGGLE_WRITE_ENABLE_BIT    2
`define URX_EP0_DT_BIT      1
`define URX_CSRH_AUTO_CLEAR_ON_UNLOAD_BIT 7
`define URX_CSRH_INCOMPLETE_RECEIVE_FLAG_BIT  0
`define URX_CSRL_RDY_BIT    0
`define URX_MODE_ISO_BIT    0
`define URX_MODE_DMA_BIT    1
`define URX_IRQ_PKT_BIT     0
`define URX_IRQ_INC_BIT     1
`define URX_IRQ_AUTO_BIT    2
// ****************************************
// reset values and widths
// ****************************************
`define URX_CSRH_RST        8'h00
`define URX_MAXP_RST        11'h040
`define URX_MAXP_W          11
`define URX_CNT_W           12
`define URX_IRQ_W           3
`define URX_SYNC_RST        3'h0
`endif

// ==== verilog/urx_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module urx_sync (
  input  wire ref_clk_i,
  input  wire rst_n_i,
  input  wire d_i,
  output reg  q_o
);
  reg [2:0] sh_r;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_r <= 3'h0;
      q_o  <= 1'b0;
    end else begin
      sh_r <= {sh_r[1:0], d_i};
      if (sh_r[1] == sh_r[2]) begin
        q_o <= sh_r[2];
      end
    end
  end
endmodule // urx_sync
`default_nettype wire

// ==== verilog/urx_unload_cnt.v ====
`timescale 1ns/1ps
`default_nettype none
`include "urx_regs.vh"
// counts bytes unloaded from the receive fifo and flags the full-size point
module urx_unload_cnt (
  input  wire                    ref_clk_i,
  input  wire                    rst_n_i,
  input  wire                    clr_i,
  input  wire                    pop_i,
  input  wire [2:0]              pop_bytes_i,
  input  wire                    dma_i,
  input  wire [`URX_MAXP_W-1:0]  maxp_i,
  output wire                    full_o
);
  reg  [`URX_CNT_W-1:0] cnt_r;
  wire [`URX_CNT_W-1:0] maxp_ext;
  wire [`URX_CNT_W-1:0] target;
  wire [`URX_CNT_W-1:0] cnt_nxt;
  assign maxp_ext = {1'b0, maxp_i};
  // dma reads whole words, so the threshold is maxp rounded up to four
  assign target  = dma_i ? ((maxp_ext + 12'h003) & 12'hFFC) : maxp_ext; // [R9] [R10]
  assign cnt_nxt = cnt_r + {9'h000, pop_bytes_i};
  assign full_o  = pop_i && (cnt_nxt >= target) && (target != 12'h000); // [R7]
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 12'h000;
    end else if (clr_i || full_o) begin
      cnt_r <= 12'h000;
    end else if (pop_i) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // urx_unload_cnt
`default_nettype wire

// ==== verilog/urx_rx_ep_ctrl.v ====
// Functional notes
// (R1) write-one arms toggle loading; enable self-clears once the toggle is written
// (R2) reading the toggle bit returns the current endpoint 0 data toggle
// (R3) toggle writes take effect only while the write enable is high
// (R4) set incomplete-receive flag on an incomplete high-bandwidth packet
// (R5) incomplete flag clears with packet-ready clear or software writing zero
// (R6) incomplete flag reads zero unless the endpoint is isochronous
// (R7) auto-clear drops packet-ready after a full max-size packet is unloaded
// (R8) short packets need software to clear packet-ready
// (R9) dma unloads in four-byte units, so threshold rounds up
// (R10) dma auto-clear count is max size rounded up to four
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "urx_regs.vh"
module urx_rx_ep_ctrl (
  input  wire                    ref_clk_i,
  input  wire                    rst_n_i,
  input  wire [`URX_ADDR_W-1:0]  addr_i,
  input  wire [7:0]              wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [7:0]              rdata_o,
  input  wire                    pkt_rx_i,
  input  wire                    pkt_incomplete_i,
  input  wire                    ep0_toggle_flip_i,
  input  wire                    fifo_pop_i,
  input  wire [2:0]              fifo_pop_bytes_i,
  input  wire                    dma_pop_i,
  input  wire                    link_ep0_toggle_i,
  output reg                     receive_packet_ready_o,
  output reg                     data_toggle_state_o,
  output reg                     irq_o
);
  // ****************************************
  // reset release
  // ****************************************
  reg  [1:0] rst_sync_r;
  wire       rst_n;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // pin input from the usb side
  // ****************************************
  wire ext_tog;
  urx_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n),
    .d_i       (link_ep0_toggle_i),
    .q_o       (ext_tog)
  );
  reg ext_tog_d_r;

  // ****************************************
  // registers
  // ****************************************
  reg                    toggle_write_enable_r;
  reg                    data_toggle_r;
  reg                    auto_clear_on_unload_r;
  reg                    incomplete_receive_flag_r;
  reg                    rdy_r;
  reg                    iso_r;
  reg                    dma_mode_r;
  reg [`URX_MAXP_W-1:0]  maxp_r;
  reg [`URX_IRQ_W-1:0]   irq_stat_r;
  reg [`URX_IRQ_W-1:0]   irq_mask_r;

  wire wr_ep0  = wr_i && (addr_i == `URX_OFF_EP0_CSRH);
  wire wr_csrh = wr_i && (addr_i == `URX_OFF_EP1_CSRH);
  wire wr_csrl = wr_i && (addr_i == `URX_OFF_EP1_CSRL);
  wire rd_stat = rd_i && (addr_i == `URX_OFF_IRQ_STAT);

  wire unload_full;
  wire pop_any = fifo_pop_i || dma_pop_i;
  urx_unload_cnt u_cnt (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n),
    .clr_i       (pkt_rx_i || !rdy_r),
    .pop_i       (pop_any && rdy_r),
    .pop_bytes_i (dma_pop_i ? 3'h4 : fifo_pop_bytes_i), // [R9]
    .dma_i       (dma_mode_r),
    .maxp_i      (maxp_r),
    .full_o      (unload_full)
  );

  wire sw_rdy_clr = wr_csrl && !wdata_i[`URX_CSRL_RDY_BIT]; // [R8]
  wire auto_clr   = auto_clear_on_unload_r && unload_full; // [R7]
  wire rdy_clr    = rdy_r && (sw_rdy_clr || auto_clr);
  wire inc_set    = pkt_rx_i && pkt_incomplete_i && iso_r; // [R4]

  // ****************************************
  // endpoint 0 data toggle
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      toggle_write_enable_r <= 1'b0;
      data_toggle_r         <= 1'b0;
      ext_tog_d_r           <= 1'b0;
    end else begin
      ext_tog_d_r <= ext_tog;
      if (wr_ep0 && toggle_write_enable_r) begin
        data_toggle_r         <= wdata_i[`URX_EP0_DT_BIT]; // [R3]
        toggle_write_enable_r <= 1'b0; // [R1]
      end else begin
        if (wr_ep0) begin
          toggle_write_enable_r <= wdata_i[`URX_EP0_TOGGLE_WRITE_ENABLE_BIT]; // [R1]
        end
        if (ep0_toggle_flip_i || (ext_tog != ext_tog_d_r)) begin
          data_toggle_r <= ~data_toggle_r;
        end
      end
    end
  end

  // ****************************************
  // receive endpoint control and status
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      auto_clear_on_unload_r    <= 1'b0;
      incomplete_receive_flag_r <= 1'b0;
      rdy_r                     <= 1'b0;
      iso_r                     <= 1'b0;
      dma_mode_r                <= 1'b0;
      maxp_r                    <= `URX_MAXP_RST;
      irq_mask_r                <= 3'h0;
    end else begin
      if (wr_csrh) begin
        auto_clear_on_unload_r <= wdata_i[`URX_CSRH_AUTO_CLEAR_ON_UNLOAD_BIT];
      end
      if (wr_i && (addr_i == `URX_OFF_MODE)) begin
        iso_r      <= wdata_i[`URX_MODE_ISO_BIT];
        dma_mode_r <= wdata_i[`URX_MODE_DMA_BIT];
      end
      if (wr_i && (addr_i == `URX_OFF_MAXP)) begin
        maxp_r <= {3'h0, wdata_i};
      end
      if (wr_i && (addr_i == `URX_OFF_IRQ_MASK)) begin
        irq_mask_r <= wdata_i[`URX_IRQ_W-1:0];
      end
      // arrival beats a clear in the same cycle
      if (pkt_rx_i) begin
        rdy_r <= 1'b1;
      end else if (rdy_clr) begin
        rdy_r <= 1'b0;
      end
      if (inc_set) begin
        incomplete_receive_flag_r <= 1'b1; // [R4]
      end else if (rdy_clr ||
                   (wr_csrh && !wdata_i[`URX_CSRH_INCOMPLETE_RECEIVE_FLAG_BIT])) begin
        incomplete_receive_flag_r <= 1'b0; // [R5]
      end
    end
  end

  // ****************************************
  // interrupt status, cleared on read
  // ****************************************
  wire [`URX_IRQ_W-1:0] irq_ev = {auto_clr && rdy_r, inc_set, pkt_rx_i};
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= 3'h0;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_r <= (rd_stat ? 3'h0 : irq_stat_r) | irq_ev;
      irq_o      <= |(((rd_stat ? 3'h0 : irq_stat_r) | irq_ev) & irq_mask_r);
    end
  end

  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  reg [7:0] rd_nxt;
  always @* begin
    rd_nxt = 8'h00;
    case (addr_i)
      `URX_OFF_EP0_CSRH: rd_nxt = {5'h00, toggle_write_enable_r, data_toggle_r, 1'b0}; // [R2]
      `URX_OFF_EP1_CSRH: rd_nxt = {auto_clear_on_unload_r, 6'h00,
                                  incomplete_receive_flag_r && iso_r}; // [R6]
      `URX_OFF_EP1_CSRL: rd_nxt = {7'h00, rdy_r};
      `URX_OFF_MAXP:     rd_nxt = maxp_r[7:0];
      `URX_OFF_MODE:     rd_nxt = {6'h00, dma_mode_r, iso_r};
      `URX_OFF_IRQ_STAT: rd_nxt = {5'h00, irq_stat_r};
      `URX_OFF_IRQ_MASK: rd_nxt = {5'h00, irq_mask_r};
      default:           rd_nxt = 8'h00;
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o                <= 8'h00;
      receive_packet_ready_o <= 1'b0;
      data_toggle_state_o    <= 1'b0;
    end else begin
      rdata_o                <= rd_i ? rd_nxt : 8'h00;
      receive_packet_ready_o <= rdy_r;
      data_toggle_state_o    <= data_toggle_r;
    end
  end
endmodule // urx_rx_ep_ctrl
`default_nettype wire

// ==== dv/urx_usb_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module urx_usb_peer (
  input  wire logic clk_i,
  output var logic  pkt_o,
  output var logic  inc_o,
  output var logic  link_o
);
  initial {pkt_o, inc_o, link_o} = 3'h0;
  // the qualifier is inverted once the pulse ends so a stale level never passes
  task automatic send(input logic inc);
    @(posedge clk_i) {pkt_o, inc_o} <= {1'h1, inc};
    @(posedge clk_i) {pkt_o, inc_o} <= {1'h0, !inc};
  endtask
  task automatic flip_link();
    @(posedge clk_i) link_o <= !link_o;
  endtask
endmodule // urx_usb_peer
`default_nettype wire

// ==== dv/urx_rx_ep_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module urx_rx_ep_ctrl_asserts (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        pkt_rx_i,
  input wire logic        ep0_toggle_flip_i,
  input wire logic        fifo_pop_i,
  input wire logic        dma_pop_i,
  input wire logic        receive_packet_ready_o,
  input wire logic        data_toggle_state_o,
  input wire logic        irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // a same-cycle flip would change the toggle the lock check holds stable; a loading write wins over a flip
  wire w0 = wr_i && addr_i == 12'h102 && !ep0_toggle_flip_i;
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
  rd_toggle_a: assert property (rd_i && addr_i == 12'h102 |=> rdata_o[1] == data_toggle_state_o)
    else $error("toggle read wrong");
  rd_unmap_a: assert property (rd_i && addr_i == 12'h200 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  toggle_load_a: assert property (w0 && wdata_i == 8'h04 ##1 w0 && wdata_i == 8'h02 |=> ##1 data_toggle_state_o)
    else $error("toggle not loaded");
  toggle_lock_a: assert property (w0 && !wdata_i[2] ##1 w0 && !wdata_i[2] |=> ##1 $stable(data_toggle_state_o))
    else $error("locked toggle changed");
  toggle_flip_a: assert property (ep0_toggle_flip_i && !wr_i |=> ##1 data_toggle_state_o != $past(data_toggle_state_o))
    else $error("toggle did not flip");
  ready_rise_a: assert property ($rose(receive_packet_ready_o) |-> $past(pkt_rx_i, 2)) else $error("ready rose alone");
  // the pop that fills the count clears packet-ready at once; the output copy lags one cycle
  ready_fall_a: assert property ($fell(receive_packet_ready_o) |-> $past(wr_i, 2) || $past(fifo_pop_i | dma_pop_i, 2))
    else $error("ready fell alone");
  toggle_load_c: cover property (w0 && wdata_i == 8'h04 ##1 w0 && wdata_i == 8'h02);
  ready_fall_c: cover property ($fell(receive_packet_ready_o));
  irq_rise_c: cover property ($rose(irq_o));
endmodule // urx_rx_ep_ctrl_asserts
bind urx_rx_ep_ctrl urx_rx_ep_ctrl_asserts u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pkt_rx_i(pkt_rx_i), .ep0_toggle_flip_i(ep0_toggle_flip_i), .fifo_pop_i(fifo_pop_i),
  .dma_pop_i(dma_pop_i), .receive_packet_ready_o(receive_packet_ready_o),
  .data_toggle_state_o(data_toggle_state_o), .irq_o(irq_o));
`default_nettype wire

// ==== dv/usb_rx_endpoint_ctrl_status_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module usb_rx_endpoint_ctrl_status_bench;
  logic        ref_clk_i = 1'h0, rst_n_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
  logic        ep0_toggle_flip_i = 1'h0, fifo_pop_i = 1'h0, dma_pop_i = 1'h0;
  logic        pkt_rx_i, pkt_incomplete_i, link_ep0_toggle_i, irq_o;
  logic        receive_packet_ready_o, data_toggle_state_o;
  logic [11:0] addr_i = 12'h000;
  logic [7:0]  wdata_i = 8'h00, rdata_o;
  logic [2:0]  fifo_pop_bytes_i = 3'h0;
  int          err_total = 0, compares = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  urx_rx_ep_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pkt_rx_i(pkt_rx_i),
    .pkt_incomplete_i(pkt_incomplete_i), .ep0_toggle_flip_i(ep0_toggle_flip_i),
    .fifo_pop_i(fifo_pop_i), .fifo_pop_bytes_i(fifo_pop_bytes_i), .dma_pop_i(dma_pop_i),
    .link_ep0_toggle_i(link_ep0_toggle_i), .receive_packet_ready_o(receive_packet_ready_o),
    .data_toggle_state_o(data_toggle_state_o), .irq_o(irq_o));
  urx_usb_peer u_peer (.clk_i(ref_clk_i), .pkt_o(pkt_rx_i), .inc_o(pkt_incomplete_i),
    .link_o(link_ep0_toggle_i));
  // ****************************************
  // bus and wait helpers
  // ****************************************
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // writes leave the strobe up so two of them can run back to back
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) {wr_i, rd_i, addr_i, wdata_i} <= {2'h2, a, d};
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk_i) {wr_i, rd_i, addr_i} <= {2'h1, a};
    @(posedge ref_clk_i) rd_i <= 1'h0;
    #1 `CHK("rdata", e, rdata_o)
  endtask
  task automatic pop(input logic d, input logic [2:0] n);
    @(posedge ref_clk_i) {wr_i, fifo_pop_i, dma_pop_i, fifo_pop_bytes_i} <= {1'h0, !d, d, n};
    @(posedge ref_clk_i) {fifo_pop_i, dma_pop_i} <= 2'h0;
  endtask
  task automatic waitv(input logic s, input logic v);
    int i;
    for (i = 0; i < 20 && (s ? data_toggle_state_o : receive_packet_ready_o) !== v; i++) begin
      @(posedge ref_clk_i) wr_i <= 1'h0;
      #1;
    end
    `CHK("level", v, s ? data_toggle_state_o : receive_packet_ready_o)
    if (i == 20) stop_test();
  endtask
  task automatic hold_ready();
    repeat (6) @(posedge ref_clk_i);
    #1 `CHK("ready", 1'h1, receive_packet_ready_o)
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_toggle();
    rdc(12'h114, 8'h40);
    rdc(12'h200, 8'h00);
    wr(12'h102, 8'h02);
    rdc(12'h102, 8'h00);
    wr(12'h102, 8'h04);
    wr(12'h102, 8'h02);
    wr(12'h102, 8'h00);
    rdc(12'h102, 8'h02);
    `CHK("toggle", 1'h1, data_toggle_state_o)
    @(posedge ref_clk_i) ep0_toggle_flip_i <= 1'h1;
    @(posedge ref_clk_i) ep0_toggle_flip_i <= 1'h0;
    rdc(12'h102, 8'h00);
    u_peer.flip_link();
    waitv(1'h1, 1'h1);
    $display("t_toggle done");
  endtask
  task automatic t_incomplete();
    u_peer.send(1'h1);
    waitv(1'h0, 1'h1);
    rdc(12'h117, 8'h00);
    wr(12'h118, 8'h01);
    rdc(12'h117, 8'h00);
    u_peer.send(1'h1);
    rdc(12'h117, 8'h01);
    wr(12'h117, 8'h00);
    rdc(12'h117, 8'h00);
    u_peer.send(1'h1);
    rdc(12'h117, 8'h01);
    `CHK("irq", 1'h0, irq_o)
    wr(12'h11D, 8'h02);
    // irq needs the new mask a cycle before it rises; the status read then drops it
    repeat (2) @(posedge ref_clk_i) wr_i <= 1'h0;
    #1 `CHK("irq", 1'h1, irq_o)
    rdc(12'h11C, 8'h03);
    `CHK("irq", 1'h0, irq_o)
    rdc(12'h11C, 8'h00);
    `CHK("irq", 1'h0, irq_o)
    wr(12'h116, 8'h00);
    rdc(12'h116, 8'h00);
    rdc(12'h117, 8'h00);
    $display("t_incomplete done");
  endtask
  task automatic t_auto();
    wr(12'h118, 8'h00);
    wr(12'h114, 8'h06);
    wr(12'h117, 8'h80);
    rdc(12'h117, 8'h80);
    u_peer.send(1'h0);
    waitv(1'h0, 1'h1);
    pop(1'h0, 3'h4);
    pop(1'h0, 3'h1);
    hold_ready();
    pop(1'h0, 3'h1);
    waitv(1'h0, 1'h0);
    u_peer.send(1'h0);
    waitv(1'h0, 1'h1);
    pop(1'h0, 3'h3);
    hold_ready();
    wr(12'h116, 8'h00);
    waitv(1'h0, 1'h0);
    wr(12'h118, 8'h02);
    wr(12'h114, 8'h09);
    rdc(12'h114, 8'h09);
    u_peer.send(1'h0);
    waitv(1'h0, 1'h1);
    pop(1'h1, 3'h4);
    pop(1'h1, 3'h4);
    hold_ready();
    pop(1'h1, 3'h4);
    waitv(1'h0, 1'h0);
    $display("t_auto done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge ref_clk_i);
    t_toggle();
    t_incomplete();
    t_auto();
    stop_test();
  end
endmodule // usb_rx_endpoint_ctrl_status_bench
`default_nettype wire
